// >>> design/lsc_pkg.sv
// Package for the layer-3 line-signal sequence checker.
// Assumes a single 40 MHz system clock; no software-visible registers.
package lsc_pkg;

	// --------------------------------------------------------------
	// Sequence numbering
	// --------------------------------------------------------------
	localparam int SEQ_W = 7;
	localparam logic [6:0] SEQ_ZERO = 7'h00;
	localparam logic [6:0] SEQ_ONE = 7'h01;
	localparam logic [6:0] WIN_MAX = 7'h7f;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam longint CLK_HZ = 40000000;
	localparam longint WAIT_SEC = 10;
	localparam longint DELAY_SEC = 5;
	localparam longint WAIT_CYC = WAIT_SEC * CLK_HZ;
	localparam longint DELAY_CYC = DELAY_SEC * CLK_HZ;
	localparam int TMR_W = 32;

	// Message kind carried on the send request
	typedef enum logic [0:0] {
		LSC_KIND_SIGNAL = 1'b0,
		LSC_KIND_PARAM = 1'b1
	} lsc_kind_e;

endpackage : lsc_pkg

// >>> design/lsc_seq_checker.sv
// Per-path layer-3 sequence numbering, acknowledgement and timer logic.
// Assumes message framing, encode and decode are done by the caller on the same clock.
//
// Summary of operation
// [RQ1] All sequence numbers are 7 bits, wrapping modulo 128.
// [RQ2] Call-start clear zeroes next-to-send, last-acknowledged and next-to-receive.
// [RQ3] Send stamps next-to-send into the message, then increments it.
// [RQ4] Next-to-send over 127 ahead of last-acknowledged releases the path.
// [RQ5] Valid send starts ack-wait timer only when idle.
// [RQ6] Outgoing ack carries current next-to-receive value.
// [RQ7] Received number equal next-to-receive accepted and counted; else release.
// [RQ8] Ack loads last-acknowledged; equal to next-to-send stops ack-wait timer.
// [RQ9] Acknowledged value valid only within next-to-send minus 127 to next-to-send.
// [RQ10] Valid ack with outstanding messages restarts ack-wait; invalid ack releases.
// [RQ11] New received message starts ack-delay timer unless already running.
// [RQ12] Ack-delay timer expiry sends an ack with next-to-receive.
// [RQ13] Ack-wait timer expiry releases the path.
// [RQ14] Ack-wait timer lasts 10 seconds.
// [RQ15] Ack-delay timer lasts 5 seconds.
// [RQ16] Link re-establishment indication ignored, no effect.
// [RQ17] Parameter messages numbered and checked like line-signal messages.
// [RQ18] Release is a one-cycle pulse; state then holds until call-start clear.
`timescale 1ns/1ps

module lsc_seq_checker
	import lsc_pkg::*;
#(
	parameter longint P_WAIT_CYC = WAIT_CYC,
	parameter longint P_DELAY_CYC = DELAY_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_call_start,
	input wire logic i_tx_req,
	input wire logic i_tx_kind,
	input wire logic i_rx_msg,
	input wire logic [6:0] i_rx_num,
	input wire logic i_rx_ack,
	input wire logic [6:0] i_rx_ack_num,
	input wire logic i_dl_reestab,
	output logic o_tx_send,
	output logic o_tx_kind,
	output logic [6:0] o_tx_num,
	output logic o_ack_send,
	output logic [6:0] o_ack_num,
	output logic o_release,
	output logic o_halted,
	output logic [6:0] o_next_send,
	output logic [6:0] o_last_ack,
	output logic [6:0] o_next_recv,
	output logic o_wait_run,
	output logic o_delay_run
);

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	localparam logic [TMR_W-1:0] WAIT_LOAD = TMR_W'(P_WAIT_CYC - 1); // [RQ14]
	localparam logic [TMR_W-1:0] DELAY_LOAD = TMR_W'(P_DELAY_CYC - 1); // [RQ15]
	localparam logic [TMR_W-1:0] TMR_ZERO = '0;

	// Modulo-128 distance a minus b; the 7-bit width does the wrap
	function automatic logic [6:0] seq_dist(input logic [6:0] a, input logic [6:0] b);
		seq_dist = a - b; // [RQ1]
	endfunction : seq_dist

	logic [6:0] next_send_ff, last_ack_ff, next_recv_ff;
	logic halted_ff;
	logic wait_run_ff, delay_run_ff;
	logic [TMR_W-1:0] wait_cnt_ff, delay_cnt_ff;

	logic tx_ok, tx_over, rx_ok, rx_bad, ack_ok, ack_bad;
	logic wait_exp, delay_exp, rel_any;
	logic [6:0] nxt_send;

	// --------------------------------------------------------------
	// Event decode
	// --------------------------------------------------------------
	// Send when window already full would put next-to-send 128 ahead
	assign tx_over = i_tx_req && !halted_ff &&
		(seq_dist(next_send_ff, last_ack_ff) == WIN_MAX); // [RQ4]
	assign tx_ok = i_tx_req && !halted_ff && !tx_over; // [RQ17]
	assign nxt_send = next_send_ff + SEQ_ONE; // [RQ3]
	assign rx_ok = i_rx_msg && !halted_ff && (i_rx_num == next_recv_ff); // [RQ7]
	assign rx_bad = i_rx_msg && !halted_ff && (i_rx_num != next_recv_ff); // [RQ7]
	// Acked value must not lie beyond next-to-send; distance <= 127 always holds
	assign ack_ok = i_rx_ack && !halted_ff &&
		(seq_dist(next_send_ff, i_rx_ack_num) <= WIN_MAX); // [RQ9]
	assign ack_bad = i_rx_ack && !halted_ff && !ack_ok; // [RQ10]
	assign wait_exp = wait_run_ff && (wait_cnt_ff == TMR_ZERO) && !halted_ff; // [RQ13]
	assign delay_exp = delay_run_ff && (delay_cnt_ff == TMR_ZERO) && !halted_ff;
	assign rel_any = tx_over || rx_bad || ack_bad || wait_exp; // [RQ18]
	// Link re-establishment needs nothing: loss shows through the numbers
	logic unused_dl;
	assign unused_dl = i_dl_reestab; // [RQ16]

	// --------------------------------------------------------------
	// Sequence counters
	// --------------------------------------------------------------
	// Call start wins over any event in the same cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			next_send_ff <= SEQ_ZERO;
			last_ack_ff <= SEQ_ZERO;
			next_recv_ff <= SEQ_ZERO;
		end else if (i_call_start) begin
			next_send_ff <= SEQ_ZERO; // [RQ2]
			last_ack_ff <= SEQ_ZERO;
			next_recv_ff <= SEQ_ZERO;
		end else if (!rel_any) begin
			if (tx_ok)
				next_send_ff <= nxt_send; // [RQ3]
			if (ack_ok)
				last_ack_ff <= i_rx_ack_num; // [RQ8]
			if (rx_ok)
				next_recv_ff <= next_recv_ff + SEQ_ONE; // [RQ7]
		end
	end

	// --------------------------------------------------------------
	// Halt after release
	// --------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			halted_ff <= 1'b0;
		else if (i_call_start)
			halted_ff <= 1'b0;
		else if (rel_any)
			halted_ff <= 1'b1; // [RQ18]
	end

	// --------------------------------------------------------------
	// Ack-wait timer
	// --------------------------------------------------------------
	// A send and an ack in one cycle: ack decides against the new next-to-send
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			wait_run_ff <= 1'b0;
			wait_cnt_ff <= TMR_ZERO;
		end else if (i_call_start) begin
			wait_run_ff <= 1'b0;
			wait_cnt_ff <= TMR_ZERO;
		end else if (rel_any || halted_ff) begin
			wait_run_ff <= 1'b0; // Frozen until next call
		end else if (ack_ok && i_rx_ack_num == (tx_ok ? nxt_send : next_send_ff)) begin
			wait_run_ff <= 1'b0; // [RQ8]
		end else if (ack_ok) begin
			wait_run_ff <= 1'b1; // [RQ10]
			wait_cnt_ff <= WAIT_LOAD;
		end else if (tx_ok && !wait_run_ff) begin
			wait_run_ff <= 1'b1; // [RQ5]
			wait_cnt_ff <= WAIT_LOAD;
		end else if (wait_run_ff) begin
			wait_cnt_ff <= wait_cnt_ff - TMR_W'(1);
		end
	end

	// --------------------------------------------------------------
	// Ack-delay timer
	// --------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			delay_run_ff <= 1'b0;
			delay_cnt_ff <= TMR_ZERO;
		end else if (i_call_start || rel_any || halted_ff) begin
			delay_run_ff <= 1'b0;
		end else if (delay_exp) begin
			// A message landing on the expiry cycle is not covered by the ack
			// just sent, so the timer must run again for it
			delay_run_ff <= rx_ok; // [RQ12] [RQ11]
			delay_cnt_ff <= DELAY_LOAD;
		end else if (rx_ok && !delay_run_ff) begin
			delay_run_ff <= 1'b1; // [RQ11]
			delay_cnt_ff <= DELAY_LOAD;
		end else if (delay_run_ff) begin
			delay_cnt_ff <= delay_cnt_ff - TMR_W'(1);
		end
	end

	// --------------------------------------------------------------
	// Registered outputs
	// --------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_tx_send <= 1'b0;
			o_tx_kind <= 1'b0;
			o_tx_num <= SEQ_ZERO;
		end else begin
			o_tx_send <= tx_ok && !rel_any && !i_call_start;
			if (tx_ok) begin
				o_tx_kind <= i_tx_kind; // [RQ17]
				o_tx_num <= next_send_ff; // [RQ3]
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_ack_send <= 1'b0;
			o_ack_num <= SEQ_ZERO;
		end else begin
			o_ack_send <= delay_exp && !rel_any && !i_call_start; // [RQ12]
			if (delay_exp)
				o_ack_num <= next_recv_ff; // [RQ6]
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			o_release <= 1'b0;
		else
			o_release <= rel_any && !i_call_start; // [RQ18]
	end

	assign o_halted = halted_ff;
	assign o_next_send = next_send_ff;
	assign o_last_ack = last_ack_ff;
	assign o_next_recv = next_recv_ff;
	assign o_wait_run = wait_run_ff;
	assign o_delay_run = delay_run_ff;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	clear_zeroes_a: assert property (i_call_start |=> // [RQ2]
		next_send_ff == SEQ_ZERO && last_ack_ff == SEQ_ZERO && next_recv_ff == SEQ_ZERO)
		else $error("counters not cleared on call start");
	send_stamp_a: assert property (tx_ok && !rel_any && !i_call_start |=> // [RQ3]
		o_tx_send && o_tx_num == $past(next_send_ff) && next_send_ff == $past(nxt_send))
		else $error("send number or increment wrong");
	window_over_a: assert property (tx_over && !i_call_start |=> o_release) // [RQ4]
		else $error("window overflow not released");
	wait_start_a: assert property (tx_ok && !wait_run_ff && !i_rx_ack && !rel_any && // [RQ5]
		!i_call_start |=> wait_run_ff && wait_cnt_ff == WAIT_LOAD)
		else $error("ack-wait timer not started");
	rx_check_a: assert property (rx_bad && !i_call_start |=> o_release && halted_ff) // [RQ7]
		else $error("bad receive number not released");
	ack_stop_a: assert property (ack_ok && !tx_ok && !rel_any && !i_call_start && // [RQ8]
		i_rx_ack_num == next_send_ff |=> !wait_run_ff && last_ack_ff == $past(i_rx_ack_num))
		else $error("full ack did not stop timer");
	delay_ack_a: assert property (delay_exp && !rel_any && !i_call_start |=> // [RQ12]
		o_ack_send && o_ack_num == $past(next_recv_ff))
		else $error("ack not sent on delay expiry");
	wait_exp_a: assert property (wait_exp && !i_call_start |=> o_release ##1 !o_release) // [RQ13]
		else $error("ack-wait expiry release wrong");
	halt_hold_a: assert property (halted_ff && !i_call_start |=> // [RQ18]
		$stable(next_send_ff) && $stable(next_recv_ff) && !o_tx_send)
		else $error("state moved while halted");

	// Accepted message moves next-to-receive on by one
	rx_accept_a: assert property (rx_ok && !rel_any && !i_call_start |=> // [RQ7]
		next_recv_ff == $past(next_recv_ff) + SEQ_ONE)
		else $error("accepted message not counted");
	// Delay timer starts from idle on a new message
	delay_start_a: assert property (rx_ok && !delay_run_ff && !rel_any && // [RQ11]
		!i_call_start |=> delay_run_ff && delay_cnt_ff == DELAY_LOAD)
		else $error("ack-delay timer not started");
	// A running delay timer is not reloaded by a further message before its expiry cycle
	delay_keep_a: assert property (rx_ok && delay_run_ff && !delay_exp && !rel_any && // [RQ11]
		!i_call_start |=> delay_run_ff && delay_cnt_ff == $past(delay_cnt_ff) - TMR_W'(1))
		else $error("ack-delay timer reloaded while running");
	// Message on the expiry cycle still gets its own ack later
	delay_again_a: assert property (delay_exp && rx_ok && !rel_any && !i_call_start |=> // [RQ11]
		delay_run_ff && delay_cnt_ff == DELAY_LOAD)
		else $error("ack-delay timer not rerun at expiry");
	// Expiry with nothing new received leaves the delay timer idle
	delay_stop_a: assert property (delay_exp && !rx_ok && !i_call_start |=> // [RQ12]
		!delay_run_ff)
		else $error("ack-delay timer kept running after expiry");
	// A send while the wait timer runs leaves it counting down
	wait_keep_a: assert property (tx_ok && wait_run_ff && !i_rx_ack && !rel_any && // [RQ5]
		!i_call_start |=> wait_run_ff && wait_cnt_ff == $past(wait_cnt_ff) - TMR_W'(1))
		else $error("ack-wait timer disturbed by send");
	// Without acks the wait timer counts one step per clock
	wait_dec_a: assert property (wait_run_ff && !i_rx_ack && !rel_any && // [RQ14]
		!i_call_start |=> wait_cnt_ff == $past(wait_cnt_ff) - TMR_W'(1))
		else $error("ack-wait timer count skipped");
	// Partial ack restarts the wait timer and is stored
	ack_restart_a: assert property (ack_ok && !rel_any && !i_call_start && // [RQ10]
		i_rx_ack_num != (tx_ok ? nxt_send : next_send_ff) |=>
		wait_run_ff && wait_cnt_ff == WAIT_LOAD && last_ack_ff == $past(i_rx_ack_num))
		else $error("partial ack did not restart timer");
	// Parameter messages keep their kind through the send path
	kind_follow_a: assert property (tx_ok && !rel_any && !i_call_start |=> // [RQ17]
		o_tx_kind == $past(i_tx_kind))
		else $error("message kind not carried");
	// Stamped number and kind hold between sends
	tx_num_hold_a: assert property (!tx_ok |=> // [RQ3]
		$stable(o_tx_num) && $stable(o_tx_kind))
		else $error("send number changed without a send");
	// Ack number holds between delay expiries
	ack_num_hold_a: assert property (!delay_exp |=> $stable(o_ack_num)) // [RQ6]
		else $error("ack number changed without an ack");
	// An in-order message never releases the path by itself
	rx_quiet_a: assert property (rx_ok && !tx_over && !wait_exp && !i_call_start |=> // [RQ7]
		!o_release && !halted_ff)
		else $error("in-order message released the path");
	// Any release cause halts the path and pulses once
	halt_set_a: assert property (rel_any && !i_call_start |=> // [RQ18]
		halted_ff && o_release ##1 !o_release)
		else $error("release did not halt the path");
	// Timers stay stopped while halted, so no ack or expiry leaks out
	timer_hold_a: assert property (halted_ff && !i_call_start |=> // [RQ18]
		!wait_run_ff && !delay_run_ff && !o_ack_send && !o_release)
		else $error("timer ran while halted");
	// Acks leave state alone while the path is halted
	halt_ack_a: assert property (halted_ff && !i_call_start |=> $stable(last_ack_ff)) // [RQ18]
		else $error("ack accepted while halted");
	// No send ever runs next-to-send past the window
	window_keep_a: assert property (tx_over && !i_call_start |=> $stable(next_send_ff)) // [RQ4]
		else $error("send went past the window");
	// Call start leaves timers stopped and every pulse low
	clear_timers_a: assert property (i_call_start |=> // [RQ2]
		!wait_run_ff && !delay_run_ff && !halted_ff && !o_release && !o_tx_send && !o_ack_send)
		else $error("call start left activity behind");

	// --------------------------------------------------------------
	// Shadow send tally
	// --------------------------------------------------------------
	// Counts send pulses as the far side sees them; kept apart from the
	// counter so that a stray or missed increment shows once sends stop
	logic [6:0] sent_tally_ff;
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			sent_tally_ff <= SEQ_ZERO;
		else if (i_call_start)
			sent_tally_ff <= SEQ_ZERO;
		else if (o_tx_send)
			sent_tally_ff <= sent_tally_ff + SEQ_ONE; // Wraps like the counter
	end

	sent_tally_a: assert property (!o_tx_send |-> sent_tally_ff == next_send_ff) // [RQ1] [RQ3]
		else $error("send count and next-to-send disagree");

	send_c: cover property (o_tx_send ##[1:20] o_tx_send);
	ack_c: cover property (o_ack_send);
	rel_c: cover property (o_release);
	// Window overflow and a partial ack are the rarer paths
	win_c: cover property (tx_over);
	restart_c: cover property (ack_ok && i_rx_ack_num != next_send_ff);

endmodule : lsc_seq_checker

// >>> dv/lsc_peer.sv
// Far-end protocol entity model facing the sequence checker.
// Assumes the bench drives the commands just after falling edges.
`timescale 1ns/1ps

module lsc_peer (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clear,
	input wire logic i_got,
	input wire logic i_do_msg,
	input wire logic i_bad,
	input wire logic i_do_ack,
	output logic o_rx_msg,
	output logic [6:0] o_rx_num,
	output logic o_rx_ack,
	output logic [6:0] o_rx_ack_num
);
	// -----------------------------------------------
	// Peer counters
	// -----------------------------------------------
	logic [6:0] ns_ff;
	logic [6:0] nr_ff;

	// Own send count and count of messages taken from the design
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ns_ff <= 7'h00;
			nr_ff <= 7'h00;
		end else if (i_clear) begin
			ns_ff <= 7'h00;
			nr_ff <= 7'h00;
		end else begin
			if (i_do_msg && !i_bad)
				ns_ff <= ns_ff + 7'h01;
			if (i_got)
				nr_ff <= nr_ff + 7'h01;
		end
	end

	// Number lines show inverted junk outside a message, never a stale value
	assign o_rx_msg = i_do_msg;
	assign o_rx_num = i_do_msg ? (i_bad ? ns_ff + 7'h01 : ns_ff) : ~ns_ff;
	assign o_rx_ack = i_do_ack;
	assign o_rx_ack_num = i_do_ack ? nr_ff : ~nr_ff;
endmodule : lsc_peer

// >>> dv/tb.sv
// Self-checking bench for the sequence checker with a far-end model.
// Assumes shortened timers: wait 400 cycles, delay 20 cycles.
`timescale 1ns/1ps

module tb;
	import lsc_pkg::*;
	localparam longint WT = 400;
	localparam longint DT = 20;
	logic i_clk = 1'b0, i_reset = 1'b1, cs = 1'b0, txr = 1'b0, txk = 1'b0, dl = 1'b0;
	logic dm = 1'b0, db = 1'b0, da = 1'b0, rm, ra, ts, tk, as, rel, hlt, wr, dr;
	logic [6:0] rn, ran, tn, an, nsd, la, nrc;
	int errors = 0, n_checks = 0, n;

	always #12.5 i_clk = ~i_clk;

	lsc_seq_checker #(.P_WAIT_CYC(WT), .P_DELAY_CYC(DT)) i_lsc_seq_checker (.i_clk(i_clk),
		.i_reset(i_reset), .i_call_start(cs), .i_tx_req(txr), .i_tx_kind(txk), .i_rx_msg(rm),
		.i_rx_num(rn), .i_rx_ack(ra), .i_rx_ack_num(ran), .i_dl_reestab(dl), .o_tx_send(ts),
		.o_tx_kind(tk), .o_tx_num(tn), .o_ack_send(as), .o_ack_num(an), .o_release(rel),
		.o_halted(hlt), .o_next_send(nsd), .o_last_ack(la), .o_next_recv(nrc),
		.o_wait_run(wr), .o_delay_run(dr));
	lsc_peer i_lsc_peer (.i_clk(i_clk), .i_reset(i_reset), .i_clear(cs), .i_got(ts),
		.i_do_msg(dm), .i_bad(db), .i_do_ack(da), .o_rx_msg(rm), .o_rx_num(rn),
		.o_rx_ack(ra), .o_rx_ack_num(ran));

	// -----------------------------------------------
	// Shared tasks
	// -----------------------------------------------
	task chk(input logic [6:0] got, input logic [6:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_n(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			errors++;
			$display("BAD %0t cycle count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_n

	// One cycle of inputs, applied once at a falling edge
	task go(input logic t, k, m, a, b, c, r);
		txr = t;
		txk = k;
		dm = m;
		da = a;
		db = b;
		cs = c;
		dl = r;
		@(negedge i_clk);
	endtask : go

	// Bounded wait for an ack pulse (sel 1) or a release pulse (sel 0)
	task wt(input logic sel, output int cnt);
		cnt = 0;
		while (((sel ? as : rel) !== 1'b1) && cnt < 1000) begin
			go(0, 0, 0, 0, 0, 0, 0);
			cnt++;
		end
	endtask : wt

	task report_and_stop;
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// -----------------------------------------------
	// Scenarios
	// -----------------------------------------------
	task t_send;
		go(1, LSC_KIND_SIGNAL, 0, 0, 0, 0, 0);
		chk({6'h00, ts}, 7'h01); chk(tn, 7'h00); chk({6'h00, wr}, 7'h01);
		go(1, LSC_KIND_PARAM, 0, 0, 0, 0, 1);
		chk(tn, 7'h01); chk({6'h00, tk}, 7'h01); chk(nsd, 7'h02);
	endtask : t_send

	task t_ack;
		// Idle cycle lets the peer count the last send before it acks
		go(0, 0, 0, 0, 0, 0, 0);
		go(0, 0, 0, 1, 0, 0, 0);
		chk(la, 7'h02); chk({6'h00, wr}, 7'h00);
		go(1, 0, 0, 0, 0, 0, 0);
		go(0, 0, 0, 0, 0, 0, 0);
		go(1, 0, 0, 1, 0, 0, 0);
		chk(la, 7'h03); chk(nsd, 7'h04); chk({6'h00, wr}, 7'h01);
	endtask : t_ack

	task t_tmo;
		wt(0, n);
		chk_n(n, int'(WT)); chk({6'h00, hlt}, 7'h01);
		go(1, 0, 0, 0, 0, 0, 0);
		chk({6'h00, rel}, 7'h00); chk({6'h00, ts}, 7'h00); chk(nsd, 7'h04);
	endtask : t_tmo

	task t_recv;
		go(0, 0, 0, 0, 0, 1, 0);
		chk(nsd, 7'h00); chk(la, 7'h00); chk(nrc, 7'h00); chk({6'h00, hlt}, 7'h00);
		go(0, 0, 1, 0, 0, 0, 0);
		chk(nrc, 7'h01); chk({6'h00, dr}, 7'h01);
		go(0, 0, 1, 0, 0, 0, 0);
		wt(1, n);
		chk_n(n + 1, int'(DT)); chk(an, 7'h02);
		go(0, 0, 1, 0, 1, 0, 0);
		chk({6'h00, rel}, 7'h01); chk(nrc, 7'h02);
	endtask : t_recv

	task t_win;
		go(0, 0, 0, 0, 0, 1, 0);
		repeat (127) go(1, 0, 0, 0, 0, 0, 0);
		chk(nsd, 7'h7f); chk({6'h00, rel}, 7'h00);
		go(1, 0, 0, 0, 0, 0, 0);
		chk({6'h00, rel}, 7'h01); chk({6'h00, ts}, 7'h00); chk(nsd, 7'h7f);
	endtask : t_win

	// Main sequence, then the watchdog that cuts a hang short
	initial begin
		repeat (2) @(negedge i_clk);
		i_reset = 1'b0;
		go(0, 0, 0, 0, 0, 1, 0);
		t_send();
		t_ack();
		t_tmo();
		t_recv();
		t_win();
		report_and_stop();
	end

	initial begin
		#(25 * 3000);
		errors++;
		report_and_stop();
	end
endmodule : tb
